// ===== pdoc_pkg.sv
// Purpose: constants and carriers for the power data object codec
// Assumes: 32-bit objects, two-bit type field in the top bits
// Notes: offsets are byte addresses on the register bus
package pdoc_pkg;
  // object type codes
  localparam logic [1:0] PDOC_TYPE_FIXED = 2'h0;
  localparam logic [1:0] PDOC_TYPE_BATT = 2'h1;
  localparam logic [1:0] PDOC_TYPE_VAR = 2'h2;
  // field positions
  localparam int PDOC_TYPE_LSB = 30;
  localparam int PDOC_VMAX_LSB = 20;
  localparam int PDOC_VMIN_LSB = 10;
  localparam int PDOC_DRP_BIT = 29;
  localparam int PDOC_HICAP_BIT = 28;
  localparam int PDOC_EXTP_BIT = 27;
  localparam int PDOC_USBC_BIT = 26;
  localparam int PDOC_DRD_BIT = 25;
  localparam int PDOC_UNCH_BIT = 24;
  localparam int PDOC_FRS_LSB = 23;
  localparam int PDOC_PEAK_LSB = 20;
  // safe 5 v in 50 mv units
  localparam logic [9:0] PDOC_SAFE5V = 10'h064;
  // register byte offsets
  localparam logic [7:0] PDOC_REG_CTRL = 8'h00;
  localparam logic [7:0] PDOC_REG_SINKCFG = 8'h04;
  localparam logic [7:0] PDOC_REG_SRC_FIX = 8'h08;
  localparam logic [7:0] PDOC_REG_SRC_VAR = 8'h0c;
  localparam logic [7:0] PDOC_REG_SRC_BAT = 8'h10;
  localparam logic [7:0] PDOC_REG_PARSE_IN = 8'h14;
  localparam logic [7:0] PDOC_REG_PARSE_A = 8'h18;
  localparam logic [7:0] PDOC_REG_PARSE_B = 8'h1c;
  localparam logic [7:0] PDOC_REG_STATUS = 8'h20;
  localparam logic [7:0] PDOC_REG_LIST_BASE = 8'h40;
  localparam logic [1:0] PDOC_RESP_OKAY = 2'h0;
  localparam logic [1:0] PDOC_RESP_SLVERR = 2'h2;
  localparam logic [31:0] PDOC_CTRL_RESET = 32'h0000_0000;
  // decoded object fields
  typedef struct packed {
    logic [1:0] kind;
    logic [9:0] volt_hi;
    logic [9:0] volt_lo;
    logic [9:0] amount;
    logic [9:0] flags;
  } pdoc_fields_s;
endpackage

// ===== pdoc_codec.sv
// Purpose: build source and sink power data objects, parse received ones
// Assumes: AXI4-Lite register access, one clock, asynchronous active-low reset
// Notes: sink list entry 0 is built from the sink config word, later entries from per-entry config words
//
// Behaviour
// - unchunked bit set only when port supports large unchunked extended messages
// - every source fixed object carries a two-bit peak current field
// - source without overload capability sends peak field zero
// - source using extended capabilities for overload also sends peak zero
// - hub downstream ports never get a nonzero peak field
// - peak codes 01, 10, 11 select three increasing overload profiles
// - source variable object: type 10, vmax, vmin 50 mV, current 10 mA
// - variable source output must stay within advertised voltage limits
// - source battery object: type 01, vmax, vmin, power in 250 mW
// - sink answers capability request with list of 32-bit objects
// - object count must equal header data-object-count field
// - sink lists at least one object, no duplicate type and voltage; code only flags a repeat of the previous entry in status
// - sink list always includes a safe 5 V fixed object
// - higher-capability flag set when full operation needs more power
// - only the safe 5 V fixed object carries bits 29..20
// - sink needing no power reports 5 V at 0 mA
// - sink fixed layout: type 00, flags 29..25, voltage, operating_current
// - bits 24..23 hold fast role swap current code
// - bits 22..20 of sink fixed object are zero
// - dual-role power flag only with role swap, fixed for lifetime
// - sink fixed object reports required voltage and operating_current
//
// Chosen here: the AXI4-Lite register port and the register addresses.
`timescale 1ns/100ps
module pdoc_codec
  import pdoc_pkg::*;
#(
  parameter int LIST_DEPTH = 7
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // static port capabilities
  input wire logic port_pr_swap,
  input wire logic port_unchunked,
  input wire logic port_is_hub_downstream,
  // axi4-lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // sink capability list out
  output logic [2:0] sink_obj_count,
  output logic [31:0] sink_list [LIST_DEPTH]
);

  initial begin
    if (LIST_DEPTH < 1 || LIST_DEPTH > 7) begin
      $error("LIST_DEPTH must be 1 to 7");
    end
  end

  // control registers
  logic [31:0] ctrl;
  logic [31:0] sink_cfg;
  logic [31:0] src_fix;
  logic [31:0] src_var;
  logic [31:0] src_bat;
  logic [31:0] parse_in;
  logic [31:0] entry_cfg [LIST_DEPTH];
  // ctrl and source fixed fields
  wire [1:0] peak_req = ctrl[1:0];
  wire ext_overload = ctrl[2];
  wire [2:0] req_count = ctrl[6:4];
  wire [9:0] fix_volt = src_fix[19:10];
  wire [9:0] fix_curr = src_fix[9:0];

  logic drp_held;
  logic drp_taken;
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      drp_held <= 1'b0;
      drp_taken <= 1'b0;
    end else if (!drp_taken) begin
      drp_held <= port_pr_swap;
      drp_taken <= 1'b1;
    end
  end

  wire [1:0] peak_code = (ext_overload || port_is_hub_downstream) ? 2'h0 : peak_req;
  wire unch_bit = port_unchunked & src_fix[PDOC_UNCH_BIT];
  wire [31:0] src_fixed_obj = {PDOC_TYPE_FIXED, drp_held, src_fix[28:25], unch_bit, 2'h0, peak_code,
                               fix_volt, fix_curr};
  // limits ordered, max not below min
  wire var_ok = src_var[29:20] >= src_var[19:10];
  wire [31:0] src_var_obj = {PDOC_TYPE_VAR, src_var[29:0]};
  wire [31:0] src_bat_obj = {PDOC_TYPE_BATT, src_bat[29:0]};

  // sink list build, entry 0 is the safe 5 v object
  // flags only in entry 0
  // entry 0 is safe 5 v
  wire need_none = sink_cfg[31];
  wire [9:0] safe_curr = need_none ? 10'h000 : sink_cfg[9:0];
  logic [LIST_DEPTH-1:0] hicap_need;
  logic [LIST_DEPTH-1:0] dup_hit;
  genvar g;
  generate
    for (g = 0; g < LIST_DEPTH; g++) begin : g_ent
      wire [1:0] kind = entry_cfg[g][31:30];
      wire used = 3'(g) < sink_obj_count;
      if (g == 0) begin : g_safe
        assign sink_list[g] = {PDOC_TYPE_FIXED, drp_held, |hicap_need, sink_cfg[27:25], sink_cfg[24:23],
                               3'h0, PDOC_SAFE5V, safe_curr};
        assign hicap_need[g] = 1'b0;
        assign dup_hit[g] = 1'b0;
      end else begin : g_other
        assign sink_list[g] = !used ? 32'h0000_0000 :
          (kind == PDOC_TYPE_FIXED) ? {PDOC_TYPE_FIXED, 10'h000, entry_cfg[g][19:0]} : entry_cfg[g];
        assign hicap_need[g] = used;
        // same type and voltage as the previous entry
        wire same_kind = sink_list[g][31:30] == sink_list[g-1][31:30];
        wire same_lo = sink_list[g][19:10] == sink_list[g-1][19:10];
        wire same_hi = sink_list[g][29:20] == sink_list[g-1][29:20];
        wire same_volt = same_lo && (kind == PDOC_TYPE_FIXED || same_hi);
        assign dup_hit[g] = used && same_kind && same_volt;
      end
    end
  endgenerate
  assign sink_obj_count = (req_count == 3'h0) ? 3'h1 :
    (req_count > 3'(LIST_DEPTH)) ? 3'(LIST_DEPTH) : req_count;
  wire sink_list_ok = ~|dup_hit;

  pdoc_fields_s parsed;
  wire [1:0] p_kind = parse_in[31:30];
  always_comb begin
    parsed = '0;
    parsed.kind = p_kind;
    case (p_kind)
      PDOC_TYPE_FIXED: begin
        parsed.volt_hi = parse_in[19:10];
        parsed.volt_lo = parse_in[19:10];
        parsed.amount = parse_in[9:0];
        parsed.flags = parse_in[29:20];
      end
      PDOC_TYPE_VAR, PDOC_TYPE_BATT: begin
        parsed.volt_hi = parse_in[29:20];
        parsed.volt_lo = parse_in[19:10];
        parsed.amount = parse_in[9:0];
      end
      default: begin
        parsed.flags = parse_in[29:20];
      end
    endcase
  end

  // axi write channel
  logic aw_hold;
  logic w_hold;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  assign s_axi_awready = !aw_hold && !s_axi_bvalid;
  assign s_axi_wready = !w_hold && !s_axi_bvalid;
  wire aw_now = aw_hold || (s_axi_awvalid && s_axi_awready);
  wire w_now = w_hold || (s_axi_wvalid && s_axi_wready);
  wire [7:0] wa = aw_hold ? aw_addr : s_axi_awaddr;
  wire [31:0] wd = w_hold ? w_data : s_axi_wdata;
  wire [3:0] ws = w_hold ? w_strb : s_axi_wstrb;
  wire do_write = aw_now && w_now && !s_axi_bvalid;
  wire [7:0] list_off = wa - PDOC_REG_LIST_BASE;
  wire wa_list = (wa >= PDOC_REG_LIST_BASE) && (list_off[7:2] < 6'(LIST_DEPTH)) && (wa[1:0] == 2'h0);
  wire sel_ctrl = wa == PDOC_REG_CTRL;
  wire sel_sinkcfg = wa == PDOC_REG_SINKCFG;
  wire sel_src_fix = wa == PDOC_REG_SRC_FIX;
  wire sel_src_var = wa == PDOC_REG_SRC_VAR;
  wire sel_src_bat = wa == PDOC_REG_SRC_BAT;
  wire sel_parse_in = wa == PDOC_REG_PARSE_IN;
  wire wa_ok = wa_list || sel_ctrl || sel_sinkcfg || sel_src_fix || sel_src_var || sel_src_bat || sel_parse_in;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      aw_hold <= 1'b0;
      w_hold <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= PDOC_RESP_OKAY;
    end else begin
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (do_write) begin
        aw_hold <= 1'b0;
        w_hold <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wa_ok ? PDOC_RESP_OKAY : PDOC_RESP_SLVERR;
      end else begin
        if (s_axi_awvalid && s_axi_awready) begin
          aw_hold <= 1'b1;
          aw_addr <= s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
          w_hold <= 1'b1;
          w_data <= s_axi_wdata;
          w_strb <= s_axi_wstrb;
        end
      end
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl <= PDOC_CTRL_RESET;
    end else if (do_write && sel_ctrl) begin
      ctrl <= merge(ctrl, wd, ws);
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      sink_cfg <= 32'h0000_0000;
    end else if (do_write && sel_sinkcfg) begin
      sink_cfg <= merge(sink_cfg, wd, ws);
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      src_fix <= 32'h0000_0000;
    end else if (do_write && sel_src_fix) begin
      src_fix <= merge(src_fix, wd, ws);
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      src_var <= 32'h0000_0000;
    end else if (do_write && sel_src_var) begin
      src_var <= merge(src_var, wd, ws);
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      src_bat <= 32'h0000_0000;
    end else if (do_write && sel_src_bat) begin
      src_bat <= merge(src_bat, wd, ws);
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      parse_in <= 32'h0000_0000;
    end else if (do_write && sel_parse_in) begin
      parse_in <= merge(parse_in, wd, ws);
    end
  end

  generate
    for (g = 0; g < LIST_DEPTH; g++) begin : g_cfg
      always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
          entry_cfg[g] <= 32'h0000_0000;
        end else if (do_write && wa_list && list_off[7:2] == 6'(g)) begin
          entry_cfg[g] <= merge(entry_cfg[g], wd, ws);
        end
      end
    end
  endgenerate

  // axi read channel
  assign s_axi_arready = !s_axi_rvalid;
  wire [7:0] ra = s_axi_araddr;
  wire [7:0] rlist_off = ra - PDOC_REG_LIST_BASE;
  wire ra_list = (ra >= PDOC_REG_LIST_BASE) && (rlist_off[7:2] < 6'(LIST_DEPTH)) && (ra[1:0] == 2'h0);
  wire [2:0] ridx = rlist_off[4:2];
  wire [31:0] status_word = {24'h0, sink_obj_count, sink_list_ok, var_ok, drp_held, 2'h0};
  logic [31:0] rd_mux;
  logic rd_ok;
  always_comb begin
    rd_mux = 32'h0000_0000;
    rd_ok = 1'b1;
    case (ra)
      PDOC_REG_CTRL: rd_mux = ctrl;
      PDOC_REG_SINKCFG: rd_mux = sink_cfg;
      PDOC_REG_SRC_FIX: rd_mux = src_fixed_obj;
      PDOC_REG_SRC_VAR: rd_mux = src_var_obj;
      PDOC_REG_SRC_BAT: rd_mux = src_bat_obj;
      PDOC_REG_PARSE_IN: rd_mux = parse_in;
      PDOC_REG_PARSE_A: rd_mux = {parsed.kind, parsed.volt_hi, parsed.volt_lo, parsed.amount};
      PDOC_REG_PARSE_B: rd_mux = {22'h0, parsed.flags};
      PDOC_REG_STATUS: rd_mux = status_word;
      default: begin
        if (ra_list) begin
          rd_mux = sink_list[ridx];
        end else begin
          rd_ok = 1'b0;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= PDOC_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_mux;
      s_axi_rresp <= rd_ok ? PDOC_RESP_OKAY : PDOC_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

// ===== pdoc_asserts.sv
// Purpose: port assertions for the codec
// Assumes: one clock, async active-low reset
// Notes: bound into every codec instance
`timescale 1ns/100ps
module pdoc_asserts
  import pdoc_pkg::*;
#(
  parameter int LIST_DEPTH = 7
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // read channel
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // sink list
  input wire logic [2:0] sink_obj_count,
  input wire logic [31:0] sink_list [LIST_DEPTH]
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  sequence s_take; s_axi_arvalid && s_axi_arready; endsequence
  sequence s_wait; s_axi_rvalid && !s_axi_rready; endsequence
  sequence s_more; sink_obj_count > 3'h1 && sink_list[1][31:30] == PDOC_TYPE_FIXED; endsequence
  property p_rd_ans; s_take |=> s_axi_rvalid; endproperty
  property p_rd_hold; s_wait |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
  property p_safe; sink_list[0][31:30] == PDOC_TYPE_FIXED && sink_list[0][19:10] == PDOC_SAFE5V; endproperty
  property p_resv; sink_list[0][22:20] == 3'h0; endproperty
  property p_hicap; sink_list[0][28] == (sink_obj_count > 3'h1); endproperty
  property p_count; sink_obj_count != 3'h0 && sink_obj_count <= LIST_DEPTH; endproperty
  property p_other; s_more |-> sink_list[1][29:20] == 10'h000; endproperty
  property p_drp; $past(reset_n, 2) |-> $stable(sink_list[0][29]); endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read answer late");
  a_rd_hold: assert property (p_rd_hold) else $error("read data dropped");
  a_safe: assert property (p_safe) else $error("safe object missing");
  a_resv: assert property (p_resv) else $error("reserved bits set");
  a_hicap: assert property (p_hicap) else $error("higher flag wrong");
  a_count: assert property (p_count) else $error("count out of range");
  a_other: assert property (p_other) else $error("other fixed has flags");
  a_drp: assert property (p_drp) else $error("dual role flag moved");
endmodule
bind pdoc_codec pdoc_asserts #(.LIST_DEPTH(LIST_DEPTH)) pdoc_asserts_i (.ref_clk, .reset_n, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .sink_obj_count, .sink_list);

// ===== pdoc_partner.sv
// Purpose: far-side reader of the sink list
// Assumes: list words and count in parallel
// Notes: reports a safe 5 v fixed object
`timescale 1ns/100ps
module pdoc_partner
  import pdoc_pkg::*;
#(
  parameter int LIST_DEPTH = 7
) (
  // list in
  input wire logic [2:0] sink_obj_count,
  input wire logic [31:0] sink_list [LIST_DEPTH],
  // result
  output logic safe_seen
);
  always_comb begin
    safe_seen = 1'b0;
    // count bounds walk, type picks layout
    for (int i = 0; i < LIST_DEPTH; i++) begin
      if (i < sink_obj_count && sink_list[i][31:30] == PDOC_TYPE_FIXED && sink_list[i][19:10] == PDOC_SAFE5V) begin
        safe_seen = 1'b1;
      end
    end
  end
endmodule

// ===== test_power_data_object_codec.sv
// Purpose: self-checking bench for the codec
// Assumes: AXI4-Lite access, 40 MHz clock
// Notes: expected words built from field positions
`timescale 1ns/100ps
module test_power_data_object_codec;
  import pdoc_pkg::*;
  logic ref_clk = 1'b0, reset_n = 1'b0, port_pr_swap = 1'b1, port_unchunked = 1'b0, port_is_hub_downstream = 1'b0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, safe_seen;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [2:0] sink_obj_count;
  logic [31:0] sink_list [7];
  int bad_count = 0, comparisons = 0;
  pdoc_codec #(.LIST_DEPTH(7)) pdoc_codec_i (.ref_clk, .reset_n, .port_pr_swap, .port_unchunked,
    .port_is_hub_downstream, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sink_obj_count, .sink_list);
  pdoc_partner #(.LIST_DEPTH(7)) pdoc_partner_i (.sink_obj_count, .sink_list, .safe_seen);
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rdw(input logic [7:0] a);
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    forever #12.5 ref_clk = ~ref_clk;
  end
  initial begin
    repeat (5000) @(posedge ref_clk);
    bad_count++;
    final_report;
  end
  initial begin
    repeat (3) @(posedge ref_clk);
    chk("reset list", sink_list[0], 32'h0001_9000);
    reset_n <= 1'b1;
    rdw(PDOC_REG_CTRL);
    chk("ctrl", rd, PDOC_CTRL_RESET);
    for (int f = 0; f < 4; f++) begin
      wr(PDOC_REG_SINKCFG, {4'h0, 3'h5, f[1:0], 13'h0, 10'h12c});
      chk("sink fixed", sink_list[0], {4'h2, 3'h5, f[1:0], 3'h0, PDOC_SAFE5V, 10'h12c});
    end
    wr(PDOC_REG_SINKCFG, 32'h8000_012c);
    chk("no power", {sink_list[0][31:30], 10'h0, sink_list[0][19:0]}, {12'h0, PDOC_SAFE5V, 10'h0});
    wr(PDOC_REG_LIST_BASE + 8'h04, {12'h3ff, 10'h0f0, 10'h096});
    wr(PDOC_REG_LIST_BASE + 8'h08, {12'h0, 10'h0f0, 10'h096});
    wr(PDOC_REG_CTRL, 32'h0000_0030);
    chk("count", {29'h0, sink_obj_count}, 32'h3);
    chk("higher", {31'h0, sink_list[0][28]}, 32'h1);
    chk("other fixed", sink_list[1], {12'h0, 10'h0f0, 10'h096});
    chk("partner", {31'h0, safe_seen}, 32'h1);
    rdw(PDOC_REG_STATUS);
    chk("status", {24'h0, rd[7:4], 1'b0, rd[2], 2'h0}, 32'h0000_0064);
    wr(PDOC_REG_SRC_VAR, {2'h0, 10'h190, 10'h064, 10'h12c});
    rdw(PDOC_REG_SRC_VAR);
    chk("src var", rd, {PDOC_TYPE_VAR, 10'h190, 10'h064, 10'h12c});
    rdw(PDOC_REG_STATUS);
    chk("var limits", {31'h0, rd[3]}, 32'h1);
    wr(PDOC_REG_SRC_BAT, {2'h3, 10'h0a4, 10'h038, 10'h0c8});
    rdw(PDOC_REG_SRC_BAT);
    chk("src bat", rd, {PDOC_TYPE_BATT, 10'h0a4, 10'h038, 10'h0c8});
    wr(PDOC_REG_SRC_FIX, 32'h0101_912c);
    for (int m = 0; m < 12; m++) begin
      port_is_hub_downstream <= (m >= 8);
      port_unchunked <= m[0];
      wr(PDOC_REG_CTRL, {25'h0, 3'h1, 1'b0, (m >= 4 && m < 8), m[1:0]});
      rdw(PDOC_REG_SRC_FIX);
      chk("src fix", rd, {3'h1, 4'h0, m[0], 2'h0, (m < 4) ? m[1:0] : 2'h0, 20'h1912c});
    end
    wr(PDOC_REG_PARSE_IN, {PDOC_TYPE_FIXED, 10'h2a5, 10'h0f0, 10'h096});
    rdw(PDOC_REG_PARSE_A);
    chk("parse fixed", rd, {PDOC_TYPE_FIXED, 10'h0f0, 10'h0f0, 10'h096});
    rdw(PDOC_REG_PARSE_B);
    chk("parse flags", rd, 32'h0000_02a5);
    wr(PDOC_REG_PARSE_IN, {PDOC_TYPE_VAR, 10'h190, 10'h064, 10'h12c});
    rdw(PDOC_REG_PARSE_A);
    chk("parse var", rd, {PDOC_TYPE_VAR, 10'h190, 10'h064, 10'h12c});
    wr(8'h30, 32'hffff_ffff);
    chk("bad wr", {30'h0, resp}, {30'h0, PDOC_RESP_SLVERR});
    rdw(8'h30);
    chk("bad rd", {rd[31:2], resp}, {30'h0, PDOC_RESP_SLVERR});
    final_report;
  end
endmodule
